// ==== ring_oscillator_control.sv ====
// Purpose: Ring oscillator control, divider, random bit and delay counter
// Assumes: One 250 MHz clock; the ring is modelled as a tick enable
// Notes:   Outputs are flops; ring frequency is a scaled behavioural model
`timescale 1ns/100ps
`default_nettype none
`include "rosc_regs.svh"
module ring_oscillator_control (
   input  wire logic              clock,
   input  wire logic              rst,
   input  wire rosc_pkg::wb_req_t wbReq,
   input  wire logic              wakeIrq,
   output var  rosc_pkg::wb_rsp_t wbRsp,
   output var  logic              ringClockOut,
   output var  logic              ringClockOutShifted,
   output var  logic              ringRunning
);
   import rosc_pkg::*;

   logic        ringEnable_reg;
   logic [11:0] rangeCode_reg;
   logic [31:0] driveLower_reg;
   logic [31:0] driveUpper_reg;
   logic        paused_reg;
   logic [5:0]  divisor_reg;
   logic [3:0]  phase_reg;
   logic [7:0]  count_reg;
   logic [15:0] ringAcc_reg;
   logic [15:0] ringInc_reg;
   logic        ringTick_reg;
   logic        ringLevel_reg;
   logic        randMeta_reg;
   logic        randSync_reg;
   logic [6:0]  halfCnt_reg;
   logic [5:0]  activeDiv_reg;
   logic        busReq;
   logic        busWrite;
   logic        busRead;
   logic [5:0]  wordAdr;
   logic [31:0] readMux;
   logic [31:0] merged;
   logic        ringRise;
   logic        runNow;
   logic [3:0]  stagesInLoop;
   logic [15:0] baseInc;
   logic [1:0]  stageBits [8];
   logic [4:0]  driveBits;
   logic [16:0] accSum;
   logic [6:0]  halfCnt_next;
   logic [5:0]  activeDiv_next;
   logic [5:0]  divEff;
   logic [6:0]  shiftIdx;
   logic [6:0]  twoDiv;

   ////////////////////////////////////////////////////////////////////////
   // Wishbone slave

   // Byte-lane merge so partial writes keep untouched lanes
   function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] wdat,
                                             input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[8*b +: 8] = wdat[8*b +: 8];
         end
      end
      return res;
   endfunction : laneMerge

   // One request per ack; ack blocks a second take of the same strobe
   assign busReq   = wbReq.cyc & wbReq.stb & ~wbRsp.ack;
   assign busWrite = busReq & wbReq.we;
   assign busRead  = busReq & ~wbReq.we;
   assign wordAdr  = {wbReq.adr[5:2], 2'b00};
   assign merged   = laneMerge(readMux, wbReq.dat, wbReq.sel);

   // Read view of every register; unmapped reads as zero
   always_comb begin
      readMux = 32'h00000000;
      case (wordAdr)
         `OFF_CTRL:    readMux = {8'h00, ringEnable_reg ? `ENA_CODE_ON : `ENA_CODE_OFF, rangeCode_reg};
         `OFF_DRIVE_LO: readMux = driveLower_reg;
         `OFF_DRIVE_HI: readMux = driveUpper_reg;
         `OFF_DORMANT: readMux = paused_reg ? `PAUSE_CODE : `WAKE_CODE;
         `OFF_DIV:     readMux = {26'h0000000, divisor_reg};
         `OFF_PHASE:   readMux = {28'h0000000, phase_reg};
         `OFF_STATUS: begin
            readMux[`ST_RUNNING] = ringRunning;
            readMux[`ST_PAUSED]  = paused_reg;
            readMux[`ST_ENABLED] = ringEnable_reg;
         end
         `OFF_RANDOM:  readMux = {31'h00000000, randSync_reg};
         `OFF_COUNT:   readMux = {24'h000000, count_reg};
         default:      readMux = 32'h00000000;
      endcase
   end

   // Answer one cycle after the strobe is seen
   always_ff @(posedge clock) begin
      if (rst) begin
         wbRsp <= '0;
      end else begin
         wbRsp.ack <= busReq;
         wbRsp.dat <= busRead ? readMux : 32'h00000000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control registers

   // Enable and range; power-up leaves the ring enabled
   always_ff @(posedge clock) begin
      if (rst) begin
         ringEnable_reg <= 1'b1;
         rangeCode_reg  <= `RANGE_RST;
      end else if (busWrite && wordAdr == `OFF_CTRL) begin
         ringEnable_reg <= merged[`ENA_MSB:`ENA_LSB] != `ENA_CODE_OFF;
         rangeCode_reg  <= merged[`RANGE_MSB:0];
      end
   end

   // Drive strength words, reserved bits kept at zero
   always_ff @(posedge clock) begin
      if (rst) begin
         driveLower_reg <= `FREQ_RST;
         driveUpper_reg <= `FREQ_RST;
      end else if (busWrite && wordAdr == `OFF_DRIVE_LO) begin
         driveLower_reg <= merged & `FREQ_MASK;
      end else if (busWrite && wordAdr == `OFF_DRIVE_HI) begin
         driveUpper_reg <= merged & `FREQ_MASK;
      end
   end

   // Pause flag; wake wins so the ring can never stay stuck.
   // Pausing touches no setting, so the ring resumes where it was.
   always_ff @(posedge clock) begin
      if (rst) begin
         paused_reg <= 1'b0;
      end else if (wakeIrq) begin
         paused_reg <= 1'b0;
      end else if (busWrite && wordAdr == `OFF_DORMANT) begin
         paused_reg <= merged == `PAUSE_CODE;
      end
   end

   // Divisor and phase shift
   always_ff @(posedge clock) begin
      if (rst) begin
         divisor_reg <= `DIV_RST;
         phase_reg   <= `PHASE_RST;
      end else if (busWrite && wordAdr == `OFF_DIV) begin
         divisor_reg <= merged[5:0];
      end else if (busWrite && wordAdr == `OFF_PHASE) begin
         phase_reg   <= merged[3:0];
      end
   end

   // Delay counter; a write beats a decrement in the same cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         count_reg <= `COUNT_RST;
      end else if (busWrite && wordAdr == `OFF_COUNT) begin
         count_reg <= merged[7:0];
      end else if (ringRise && count_reg != `COUNT_RST) begin
         count_reg <= count_reg - 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Ring model

   // Loop length from the gray-coded range; unknown codes mean low.
   // Neighbouring codes differ in one bit, so an upward step is clean.
   always_comb begin
      unique case (rangeCode_reg)
         `RANGE_MEDIUM: begin stagesInLoop = `STAGES_MEDIUM; baseInc = `INC_MEDIUM; end
         `RANGE_HIGH:   begin stagesInLoop = `STAGES_HIGH;   baseInc = `INC_HIGH;   end
         `RANGE_OVER:   begin stagesInLoop = `STAGES_OVER;   baseInc = `INC_OVER;   end
         default:       begin stagesInLoop = `STAGES_LOW;    baseInc = `INC_LOW;    end
      endcase
   end

   // Per-stage drive: count of set bits, gated by key and loop membership
   for (genvar i = 0; i < 8; i++) begin : g_stage
      logic [2:0] field;
      logic       keyOk;
      if (i < 4) begin : g_lo
         assign field = driveLower_reg[4*i +: 3];
         assign keyOk = driveLower_reg[`KEY_MSB:`KEY_LSB] == `DRIVE_KEY;
      end else begin : g_hi
         assign field = driveUpper_reg[4*(i-4) +: 3];
         assign keyOk = driveUpper_reg[`KEY_MSB:`KEY_LSB] == `DRIVE_KEY;
      end
      assign stageBits[i] = (keyOk && 4'(i) < stagesInLoop) ?
                            2'({1'b0, field[0]} + {1'b0, field[1]} + {1'b0, field[2]}) : 2'h0;
   end

   // Total drive of the stages in the loop
   always_comb begin
      driveBits = 5'h00;
      for (int s = 0; s < 8; s++) begin
         driveBits = 5'(driveBits + {3'h0, stageBits[s]});
      end
   end

   assign runNow   = ringEnable_reg & ~paused_reg;
   assign accSum   = {1'b0, ringAcc_reg} + {1'b0, ringInc_reg};
   assign ringRise = ringTick_reg & ~ringLevel_reg;

   // Rate follows the controls one cycle later, no settling wait
   always_ff @(posedge clock) begin
      if (rst) begin
         ringInc_reg <= `INC_LOW;
      end else begin
         ringInc_reg <= 16'(baseInc + 16'(driveBits) * `DRIVE_STEP);
      end
   end

   // Phase accumulator; a carry is one ring half period
   always_ff @(posedge clock) begin
      if (rst) begin
         ringAcc_reg   <= 16'h0000;
         ringTick_reg  <= 1'b0;
         ringLevel_reg <= 1'b0;
         ringRunning   <= 1'b1;
      end else begin
         ringRunning <= runNow;
         if (runNow) begin
            ringAcc_reg  <= accSum[15:0];
            ringTick_reg <= accSum[16];
         end else begin
            ringTick_reg <= 1'b0;
         end
         if (ringTick_reg) begin
            ringLevel_reg <= ~ringLevel_reg;
         end
      end
   end

   // Two-flop synchroniser on the ring level for the random bit
   always_ff @(posedge clock) begin
      if (rst) begin
         randMeta_reg <= 1'b0;
         randSync_reg <= 1'b0;
      end else begin
         randMeta_reg <= ringLevel_reg;
         randSync_reg <= randMeta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output divider

   // A zero divisor acts as one
   assign divEff = (divisor_reg == 6'h00) ? `DIV_ONE : divisor_reg;

   // New divisor only at a period boundary, so no short pulse appears on the main output
   always_comb begin
      halfCnt_next   = halfCnt_reg;
      activeDiv_next = activeDiv_reg;
      if (ringTick_reg) begin
         if (halfCnt_reg == 7'({activeDiv_reg, 1'b0} - 7'h01)) begin
            halfCnt_next   = 7'h00;
            activeDiv_next = divEff;
         end else begin
            halfCnt_next = 7'(halfCnt_reg + 7'h01);
         end
      end
   end

   // Shifted copy: half-count delayed by a phase setting below twice the divisor, wrapped
   always_comb begin
      twoDiv = {activeDiv_next, 1'b0};
      if ({3'h0, phase_reg} >= twoDiv) begin
         shiftIdx = halfCnt_next;
      end else if (halfCnt_next >= {3'h0, phase_reg}) begin
         shiftIdx = 7'(halfCnt_next - {3'h0, phase_reg});
      end else begin
         shiftIdx = 7'(halfCnt_next + twoDiv - {3'h0, phase_reg});
      end
   end

   // Main output high for the first half of each divided period, shifted output delayed by a phase setting below a full period
   always_ff @(posedge clock) begin
      if (rst) begin
         halfCnt_reg         <= 7'h00;
         activeDiv_reg       <= `DIV_RST;
         ringClockOut        <= 1'b1;
         ringClockOutShifted <= 1'b1;
      end else begin
         halfCnt_reg         <= halfCnt_next;
         activeDiv_reg       <= activeDiv_next;
         ringClockOut        <= halfCnt_next < {1'b0, activeDiv_next};
         ringClockOutShifted <= shiftIdx < {1'b0, activeDiv_next};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence pauseWrite;
      busWrite && wordAdr == `OFF_DORMANT && merged == `PAUSE_CODE && !wakeIrq;
   endsequence
   sequence ringHalted;
      !ringRunning && !ringTick_reg;
   endsequence

   boot_defaults_a: assert property ($fell(rst) |-> ringEnable_reg && divisor_reg == `DIV_RST && ringRunning)
      else $error("Boot defaults wrong");
   pause_stops_a: assert property (pauseWrite |=> ##1 ringHalted)
      else $error("Ring kept running after pause");
   wake_restart_a: assert property (paused_reg && wakeIrq && ringEnable_reg |=> ##1 ringRunning)
      else $error("Ring did not restart on wake");
   drive_key_a: assert property (driveLower_reg[`KEY_MSB:`KEY_LSB] != `DRIVE_KEY
                                 |-> stageBits[0] == 2'h0 && stageBits[3] == 2'h0)
      else $error("Drive applied without key");
   enable_decode_a: assert property (busWrite && wordAdr == `OFF_CTRL && wbReq.sel[1] && wbReq.sel[2]
                                     && wbReq.dat[`ENA_MSB:`ENA_LSB] != `ENA_CODE_OFF |=> ringEnable_reg)
      else $error("Enable code decoded wrong");
   disable_decode_a: assert property (busWrite && wordAdr == `OFF_CTRL && wbReq.sel[1] && wbReq.sel[2]
                                      && wbReq.dat[`ENA_MSB:`ENA_LSB] == `ENA_CODE_OFF |=> !ringEnable_reg)
      else $error("Disable code decoded wrong");
   count_hold_a: assert property (count_reg == `COUNT_RST && !(busWrite && wordAdr == `OFF_COUNT)
                                   |=> count_reg == `COUNT_RST)
      else $error("Counter left zero");
   count_load_a: assert property (busWrite && wordAdr == `OFF_COUNT |=> count_reg == $past(merged[7:0]))
      else $error("Counter load wrong");
   count_step_a: assert property (ringRise && count_reg != `COUNT_RST
                                  && !(busWrite && wordAdr == `OFF_COUNT)
                                  |=> count_reg == 8'($past(count_reg) - 8'h01))
      else $error("Counter step wrong");
   phase_same_a: assert property ($past(phase_reg) == `PHASE_RST |-> ringClockOut == ringClockOutShifted)
      else $error("Outputs differ at zero phase");
   div_clean_a: assert property ($changed(ringClockOut) |-> $past(ringTick_reg))
      else $error("Divider output moved off a ring tick");
   random_read_a: assert property (busRead && wordAdr == `OFF_RANDOM |=> wbRsp.dat[0] == $past(randSync_reg))
      else $error("Random bit not returned");
   div_load_a: assert property ($changed(activeDiv_reg) |-> $past(ringTick_reg) && halfCnt_reg == 7'h00)
      else $error("Divisor loaded mid-period");
endmodule : ring_oscillator_control
`default_nettype wire

// ==== rosc_pkg.sv ====
// Purpose: Types shared by the ring oscillator control block
// Assumes: Classic Wishbone slave, byte address on adr
// Notes:   Constants live in rosc_regs.svh
`default_nettype none
package rosc_pkg;
   `include "rosc_regs.svh"

   // Wishbone request from the master
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [5:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } wb_req_t;

   // Wishbone answer to the master
   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } wb_rsp_t;
endpackage : rosc_pkg
`default_nettype wire

// ==== rosc_regs.svh ====
// Purpose: Register map, codes and timing for the ring oscillator control block
// Assumes: Wishbone byte addresses, 32-bit data, 250 MHz system clock
// Notes:   Included by the package and by the design module
`ifndef ROSC_REGS_SVH
`define ROSC_REGS_SVH

// Register byte offsets
`define OFF_CTRL      6'h00
`define OFF_DRIVE_LO  6'h04
`define OFF_DRIVE_HI  6'h08
`define OFF_DORMANT   6'h0c
`define OFF_DIV       6'h10
`define OFF_PHASE     6'h14
`define OFF_STATUS    6'h18
`define OFF_RANDOM    6'h1c
`define OFF_COUNT     6'h20

// Control register fields and codes
`define ENA_MSB       23
`define ENA_LSB       12
`define RANGE_MSB     11
`define ENA_CODE_OFF  12'hd1e
`define ENA_CODE_ON   12'hfab
`define RANGE_RST     12'haa0
`define RANGE_LOW     12'hfa4
`define RANGE_MEDIUM  12'hfa5
`define RANGE_HIGH    12'hfa7
`define RANGE_OVER    12'hfa6

// Drive strength registers
`define KEY_MSB       31
`define KEY_LSB       16
`define DRIVE_KEY     16'h9696
`define FREQ_MASK     32'hffff7777
`define FREQ_RST      32'h00000000

// Pause codes
`define PAUSE_CODE    32'h636f6d61
`define WAKE_CODE     32'h77616b65

// Divider, phase and counter
`define DIV_RST       6'h10
`define DIV_ONE       6'h01
`define PHASE_RST     4'h0
`define COUNT_RST     8'h00

// Status bit positions
`define ST_RUNNING    31
`define ST_PAUSED     16
`define ST_ENABLED    12

// Stage counts per range
`define STAGES_LOW    4'h8
`define STAGES_MEDIUM 4'h6
`define STAGES_HIGH   4'h4
`define STAGES_OVER   4'h2

// Ring model: boot ring = 16 x 6.5 MHz, scaled down by RING_SCALE
`define CLK_KHZ       64'd250000
`define BOOT_KHZ      64'd6500
`define RING_SCALE    64'd8
`define INC_LOW       16'(((`BOOT_KHZ * 64'd32 * 64'd65536) / (`CLK_KHZ * `RING_SCALE)))
`define INC_MEDIUM    16'((`INC_LOW * 4) / 3)
`define INC_HIGH      16'(`INC_LOW * 2)
`define INC_OVER      16'(`INC_LOW * 4)
`define DRIVE_STEP    16'(`INC_LOW / 8)

`endif

// ==== testbench.sv ====
// Purpose: Self-checking bench for the ring oscillator control block
// Assumes: 250 MHz clock, Wishbone ack one cycle after a request is taken
// Notes:   Driver queues expected read data, a monitor compares at each ack
`timescale 1ns/100ps
`default_nettype none
`include "rosc_regs.svh"
module testbench;
   import rosc_pkg::*;
   typedef struct packed {
      logic [31:0] e;
      logic [31:0] m;
   } note_t;
   localparam logic [5:0] driveLowAdr = 6'h04;
   logic        clock;
   logic        rst;
   wb_req_t     wbReq;
   logic        wakeIrq;
   wb_rsp_t     wbRsp;
   logic        ringClockOut;
   logic        ringClockOutShifted;
   logic        ringRunning;
   note_t       notes[$];
   note_t       cur;
   logic [31:0] lastRd;
   logic [31:0] v;
   logic        prevOut;
   logic        glitchArm;
   logic        sameArm;
   int          runLen;
   int          num_errors;
   int          samples_checked;
   int          seed = 42248;
   int          n;
   int          k;

   ring_oscillator_control ring_oscillator_control_inst (
      .clock              (clock),
      .rst                (rst),
      .wbReq              (wbReq),
      .wakeIrq            (wakeIrq),
      .wbRsp              (wbRsp),
      .ringClockOut       (ringClockOut),
      .ringClockOutShifted(ringClockOutShifted),
      .ringRunning        (ringRunning)
   );

   ////////////////////////////////////////////////////////////////////////
   // Clock, 4 ns period
   initial clock = 1'b0;
   always #2 clock = ~clock;

   task automatic chk(input logic ok, input string msg);
      samples_checked++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask : chk

   task automatic test_done(input string name);
      $display("test %s done", name);
   endtask : test_done

   task automatic end_of_test();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_of_test

   ////////////////////////////////////////////////////////////////////////
   // One classic cycle; request held until ack is sampled high
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [31:0] e, input logic [31:0] m);
      int c;
      c = 0;
      notes.push_back('{e, m});
      wbReq <= '{1'b1, 1'b1, w, a, s, d};
      do begin
         @(posedge clock);
         c++;
      end while (wbRsp.ack !== 1'b1);
      chk(c == 2, "bus answer late");
      lastRd = wbRsp.dat;
      wbReq <= '0;
      @(posedge clock);
   endtask : bus

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hf, 32'h0, 32'h0);
   endtask : wr

   task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
      bus(1'b0, a, 32'h0, 4'hf, e, m);
   endtask : rd

   // Waits for a rising edge of the divided clock, counting cycles
   task automatic rise(output int c);
      c = 0;
      while (ringClockOut !== 1'b0 && c < 3000) begin
         @(posedge clock);
         c++;
      end
      while (ringClockOut !== 1'b1 && c < 3000) begin
         @(posedge clock);
         c++;
      end
   endtask : rise

   // Skips the period in which a new divisor may load, then measures one
   task automatic per(input int inc, input int ticks, input string msg);
      int c;
      int e;
      rise(c);
      rise(c);
      rise(c);
      e = ticks * 65536 / inc;
      chk(c >= e - 2 && c <= e + 2, msg);
   endtask : per

   task automatic reset_reads();
      rd(`OFF_CTRL, 32'h00fabaa0);
      rd(driveLowAdr, 32'h0);
      rd(`OFF_DRIVE_HI, 32'h0);
      rd(`OFF_DORMANT, `WAKE_CODE);
      rd(`OFF_DIV, 32'h10);
      rd(`OFF_PHASE, 32'h0);
      rd(`OFF_STATUS, 32'h80001000);
      rd(`OFF_COUNT, 32'h0);
      rd(6'h24, 32'h0);
   endtask : reset_reads

   ////////////////////////////////////////////////////////////////////////
   // Read data monitor: oldest note against each ack
   always @(posedge clock) begin
      if (wbRsp.ack === 1'b1) begin
         if (notes.size() == 0) begin
            chk(1'b0, "ack without request");
         end else begin
            cur = notes.pop_front();
            chk(((wbRsp.dat ^ cur.e) & cur.m) === 32'h0, "read data mismatch");
         end
      end
   end

   // Output shape monitor; a level under two cycles counts as a glitch
   always @(posedge clock) begin
      if (ringClockOut !== prevOut) begin
         if (glitchArm) chk(runLen >= 2, "divided clock glitch");
         runLen = 0;
      end
      runLen++;
      prevOut = ringClockOut;
      if (sameArm) chk(ringClockOutShifted === ringClockOut, "outputs differ");
   end

   // Watchdog sized well above the whole sequence
   initial begin
      #200000;
      num_errors++;
      $display("[ERR] %0t watchdog expired", $time);
      end_of_test();
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rst = 1'b1;
      wbReq = '0;
      wakeIrq = 1'b0;
      glitchArm = 1'b0;
      sameArm = 1'b1;
      runLen = 0;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      chk(ringRunning === 1'b1, "ring idle after reset");
      reset_reads();
      per(`INC_LOW, 32, "boot period");
      test_done("reset");
      // Enable codes, reserved bits read zero
      wr(`OFF_CTRL, 32'hffd1efa4);
      chk(ringRunning === 1'b0, "ring still running");
      rd(`OFF_CTRL, 32'h00d1efa4);
      rd(`OFF_STATUS, 32'h0);
      v = $random(seed);
      if (v[23:12] == 12'hd1e) v[12] = ~v[12];
      wr(`OFF_CTRL, {v[31:12], 12'hfa4});
      rd(`OFF_CTRL, 32'h00fabfa4);
      chk(ringRunning === 1'b1, "ring not restarted");
      test_done("enable");
      // Drive strength counts set bits only under the key
      glitchArm = 1'b1;
      wr(`OFF_DIV, 32'h4);
      // Drive raised one bit per write for smooth steps
      v = 32'h96960000;
      for (k = 0; k < 16; k++) begin
         if (k % 4 != 3) begin
            v[k] = 1'b1;
            wr(driveLowAdr, v);
         end
      end
      wr(driveLowAdr, 32'h9696ffff);
      rd(driveLowAdr, 32'h96967777);
      per(`INC_LOW + 12 * `DRIVE_STEP, 8, "full drive");
      for (k = 0; k < 16; k++) begin
         if (k % 4 == 1 || k % 4 == 2) begin
            v[k] = 1'b0;
            wr(driveLowAdr, v);
         end
      end
      per(`INC_LOW + 4 * `DRIVE_STEP, 8, "single drive");
      wr(driveLowAdr, 32'h12341111);
      per(`INC_LOW, 8, "unkeyed drive");
      wr(driveLowAdr, 32'h0);                                // all stages equal before shortening
      test_done("drive");
      // Ranges stepped up without glitch, then back down
      wr(`OFF_CTRL, 32'h00fabfa5);
      per(`INC_MEDIUM, 8, "medium range");
      wr(`OFF_CTRL, 32'h00fabfa7);                           // stops below overspeed
      per(`INC_HIGH, 8, "high range");
      glitchArm = 1'b0;                                      // ring users held off
      wr(`OFF_CTRL, 32'h00fabfa5);
      wr(`OFF_CTRL, 32'h00fabfa4);
      per(`INC_LOW, 8, "low range");
      glitchArm = 1'b1;
      test_done("range");
      // Random divisors changed while running, zero acts as one
      wr(`OFF_DIV, 32'h0);
      per(`INC_LOW, 2, "divisor zero");
      repeat (3) begin
         v = $random(seed);
         wr(`OFF_DIV, {v[31:6], 1'b0, v[4:0]});
         rd(`OFF_DIV, {27'h0, v[4:0]});
         per(`INC_LOW, (v[4:0] == 5'h0) ? 2 : 2 * v[4:0], "divisor");
      end
      test_done("divider");
      // Phase shift of half a period gives the complement
      wr(`OFF_DIV, 32'h4);
      sameArm = 1'b0;
      wr(`OFF_PHASE, 32'h4);
      bus(1'b1, `OFF_PHASE, 32'h0000ff00, 4'b0010, 32'h0, 32'h0);
      rd(`OFF_PHASE, 32'h4);
      rise(n);
      k = 0;
      repeat (100) begin
         @(posedge clock);
         if (ringClockOutShifted !== ~ringClockOut) k++;
      end
      chk(k == 0, "shifted output not complement");
      wr(`OFF_PHASE, 32'h0);
      rise(n);
      sameArm = 1'b1;
      test_done("phase");
      // Pause freezes the ring, wake restarts with settings kept
      wr(`OFF_DORMANT, `PAUSE_CODE);
      chk(ringRunning === 1'b0, "ring not paused");
      rd(`OFF_STATUS, 32'h00011000);
      rd(`OFF_DORMANT, `PAUSE_CODE);
      v[0] = ringClockOut;
      k = 0;
      repeat (400) begin
         @(posedge clock);
         if (ringClockOut !== v[0]) k++;
      end
      chk(k == 0, "clock moved while paused");
      wakeIrq <= 1'b1;
      @(posedge clock);
      wakeIrq <= 1'b0;
      repeat (2) @(posedge clock);
      chk(ringRunning === 1'b1, "ring not woken");
      rd(`OFF_DORMANT, `WAKE_CODE);
      rd(`OFF_CTRL, 32'h00fabfa4);
      rd(`OFF_DIV, 32'h4);
      per(`INC_LOW, 8, "period after wake");
      test_done("pause");
      // Delay counter runs down at ring rate and holds at zero
      wr(`OFF_COUNT, 32'h10);
      n = 0;
      do begin
         rd(`OFF_COUNT, 32'h0, 32'hffffff00);
         n = n + 3;
         if (n == 3) chk(lastRd[7:0] != 8'h0 && lastRd[7:0] <= 8'h10, "count not loaded");
      end while (lastRd[7:0] !== 8'h0 && n < 1000);
      k = 32 * 65536 / `INC_LOW;
      chk(n >= k - 25 && n <= k + 10, "countdown time");
      repeat (50) @(posedge clock);
      rd(`OFF_COUNT, 32'h0);
      test_done("count");
      // Random bit: upper bits zero, both levels seen
      k = 0;
      repeat (64) begin
         rd(`OFF_RANDOM, 32'h0, 32'hfffffffe);
         k = k + lastRd[0];
         repeat ($unsigned($random(seed)) % 8) @(posedge clock);
      end
      chk(k > 0 && k < 64, "random bit stuck");
      test_done("random");
      // Second reset in mid-run
      glitchArm = 1'b0;
      rst <= 1'b1;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      reset_reads();
      per(`INC_LOW, 32, "period after reset");
      test_done("rerun");
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
